/* File: common/aadm_defines.svh */
// Register indexes, field positions and reset values of the alarm and mute supervisor
`ifndef AADM_DEFINES_SVH
`define AADM_DEFINES_SVH

// Register indexes; byte address is four times the index
`define AADM_IDX_SYNC_STATUS 16'h0410
`define AADM_IDX_ALARM_STATUS 16'h0430
`define AADM_IDX_ALARM_MASK 16'h0431
`define AADM_IDX_MUTE_MASK 16'h0432
`define AADM_IDX_DAC_MUTE_RECOVERY 16'h0433
`define AADM_IDX_LINK_CTRL 16'h0440
`define AADM_IDX_LINK_TIMEOUT 16'h0441
`define AADM_IDX_SUPV_STATE 16'h0442

`define AADM_ADDR_W 16
`define AADM_LANES 16
`define AADM_TMO_W 24

// System alarm status fields
`define AADM_ALM_LINK_DOWN 7
`define AADM_ALM_LINK_TMO 6
`define AADM_ALM_LANE_CRC 5
`define AADM_ALM_CHIP_RST 1
`define AADM_ALM_SYSREF 0
`define AADM_ALM_WMASK 8'hE3
`define AADM_ALM_RST 8'h02

// Synchronization status fields
`define AADM_SYNC_NCO 1
`define AADM_SYNC_SYSREF 0

// Mask and recovery fields
`define AADM_MMASK_CRC 5
`define AADM_MMASK_SYSREF 0
`define AADM_REC_LINK 7
`define AADM_REC_CRC 5
`define AADM_ALARM_OUTPUT_MASK_RST 8'h00
`define AADM_MUTE_MASK_RST 8'h21
`define AADM_DAC_MUTE_RECOVERY_RST 8'hA0

// Link control fields
`define AADM_CTL_ENABLE 0
`define AADM_CTL_MODE66 1
`define AADM_CTL_LANE_LSB 8
`define AADM_CTL_RST 32'h0000_0000
`define AADM_TMO_RST 24'hFF_FFFF

`endif

/* File: common/aadm_pkg.sv */
// Types shared by the alarm and mute supervisor modules
`default_nettype none
package aadm_pkg;
    typedef struct packed {
        logic [7:0] alarm;
        logic [7:0] alarm_mask;
        logic [7:0] mute_mask;
        logic [7:0] dac_mute_recovery;
        logic [1:0] sync_flags;
        logic [31:0] link_ctrl;
        logic [23:0] timeout;
        logic link_up_prev;
        logic [31:0] rdata;
        logic alarm_out;
        logic mute_out;
    } aadm_top_state_t;

    typedef enum logic [1:0] {
        AADM_TMR_IDLE,
        AADM_TMR_COUNT,
        AADM_TMR_EXPIRED
    } aadm_tmr_mode_t;

    typedef struct packed {
        aadm_tmr_mode_t mode;
        logic [23:0] count;
        logic expired;
    } aadm_tmr_state_t;
endpackage
`default_nettype wire

/* File: common/aadm_tmr_if.sv */
// Carrier between the supervisor and its link-down timer
`default_nettype none
interface aadm_tmr_if;
    logic run;
    logic [23:0] limit;
    logic expired;

    modport ctl (
        output run,
        output limit,
        input expired
    );

    modport tmr (
        input run,
        input limit,
        output expired
    );
endinterface
`default_nettype wire

/* File: rtl/aadm_link_timer.sv */
// Link-down timer: pulses once when the link stays down past the limit
`default_nettype none
`include "aadm_defines.svh"
module aadm_link_timer (
    input wire logic clock,
    input wire logic sys_rst,
    aadm_tmr_if.tmr tif
);
    aadm_pkg::aadm_tmr_state_t s_q;
    aadm_pkg::aadm_tmr_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.expired = 1'b0;
        case (s_q.mode)
            aadm_pkg::AADM_TMR_IDLE: begin
                s_d.count = '0;
                if (tif.run) begin
                    s_d.mode = aadm_pkg::AADM_TMR_COUNT;
                end
            end
            aadm_pkg::AADM_TMR_COUNT: begin
                if (!tif.run) begin
                    s_d.mode = aadm_pkg::AADM_TMR_IDLE;
                end else if (s_q.count >= tif.limit) begin
                    // Down for more than limit cycles: one event, then hold
                    s_d.expired = 1'b1;
                    s_d.mode = aadm_pkg::AADM_TMR_EXPIRED;
                end else begin
                    s_d.count = s_q.count + 24'h00_0001;
                end
            end
            aadm_pkg::AADM_TMR_EXPIRED: begin
                // One event per outage; rearm only after link up or disable
                if (!tif.run) begin
                    s_d.mode = aadm_pkg::AADM_TMR_IDLE;
                end
            end
            default: begin
                s_d.mode = aadm_pkg::AADM_TMR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '{mode: aadm_pkg::AADM_TMR_IDLE, count: 24'h00_0000, expired: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign tif.expired = s_q.expired;
endmodule
`default_nettype wire

/* File: rtl/aadm_top.sv */
// Alarm and DAC mute supervisor with APB register access
//
// The APB slave port was left to the implementer.
`default_nettype none
`include "aadm_defines.svh"
module aadm_top (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nco_sync_event,
    input wire logic sysref_event,
    input wire logic sysref_misalign_div,
    input wire logic sysref_misalign_link,
    input wire logic link_up,
    input wire logic [15:0] lane_crc_fault,
    input wire logic soft_reset_event,
    output logic alarm_out,
    output logic dac_mute,
    output logic serial_link_enable
);
    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    function automatic logic hit(input logic [15:0] addr, input logic [15:0] idx);
        logic [17:0] byte_addr;
        byte_addr = {idx, 2'b00};
        hit = ({2'b00, addr} == byte_addr);
    endfunction

    function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] clr, input logic [7:0] set);
        // Set wins over a clear in the same cycle so no event is lost
        w1c = (cur & ~clr) | set;
    endfunction

    aadm_pkg::aadm_top_state_t s_q;
    aadm_pkg::aadm_top_state_t s_d;

    logic acc;
    logic wr;
    logic rd_setup;
    logic sel_sync;
    logic sel_alarm;
    logic sel_amask;
    logic sel_mmask;
    logic sel_rec;
    logic sel_ctrl;
    logic sel_tmo;
    logic sel_state;
    logic mapped;
    logic link_en;
    logic mode66;
    logic [15:0] lane_en;
    logic crc_now;
    logic link_fall;
    logic misalign;
    logic [7:0] alarm_set;
    logic [7:0] alarm_clr;
    logic [1:0] sync_set;
    logic [1:0] sync_clr;
    logic [7:0] alarm_gate;
    logic mute_link;
    logic mute_crc;
    logic mute_sysref;
    logic [31:0] rd_mux;

    aadm_tmr_if tif ();

    aadm_link_timer u_timer (
        .clock(clock),
        .sys_rst(sys_rst),
        .tif(tif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign sel_sync = hit(paddr, `AADM_IDX_SYNC_STATUS);
    assign sel_alarm = hit(paddr, `AADM_IDX_ALARM_STATUS);
    assign sel_amask = hit(paddr, `AADM_IDX_ALARM_MASK);
    assign sel_mmask = hit(paddr, `AADM_IDX_MUTE_MASK);
    assign sel_rec = hit(paddr, `AADM_IDX_DAC_MUTE_RECOVERY);
    assign sel_ctrl = hit(paddr, `AADM_IDX_LINK_CTRL);
    assign sel_tmo = hit(paddr, `AADM_IDX_LINK_TIMEOUT);
    assign sel_state = hit(paddr, `AADM_IDX_SUPV_STATE);
    assign mapped = sel_sync | sel_alarm | sel_amask | sel_mmask | sel_rec | sel_ctrl | sel_tmo | sel_state;

    // Zero wait states: read data is captured in the setup cycle
    assign acc = psel & penable;
    assign wr = acc & pwrite & mapped;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready = acc;
    assign pslverr = acc & ~mapped;
    assign prdata = s_q.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Link-side events

    assign link_en = s_q.link_ctrl[`AADM_CTL_ENABLE];
    assign mode66 = s_q.link_ctrl[`AADM_CTL_MODE66];
    assign lane_en = s_q.link_ctrl[`AADM_CTL_LANE_LSB +: `AADM_LANES];
    assign serial_link_enable = link_en;

    assign link_fall = s_q.link_up_prev & ~link_up & link_en;
    assign crc_now = mode66 & (|(lane_crc_fault & lane_en));
    // Link-side misalignment is only trusted while the link is enabled
    assign misalign = sysref_misalign_div | (sysref_misalign_link & link_en);

    assign tif.run = link_en & ~link_up;
    assign tif.limit = s_q.timeout;

    always_comb begin
        alarm_set = 8'h00;
        alarm_set[`AADM_ALM_LINK_DOWN] = link_fall;
        alarm_set[`AADM_ALM_LINK_TMO] = tif.expired;
        alarm_set[`AADM_ALM_LANE_CRC] = crc_now;
        alarm_set[`AADM_ALM_CHIP_RST] = soft_reset_event;
        alarm_set[`AADM_ALM_SYSREF] = misalign;
    end

    always_comb begin
        sync_set = 2'b00;
        sync_set[`AADM_SYNC_NCO] = nco_sync_event;
        sync_set[`AADM_SYNC_SYSREF] = sysref_event;
    end

    // Only implemented alarm bits clear; reserved bits stay zero
    assign alarm_clr = (wr & sel_alarm & pstrb[0]) ? (pwdata[7:0] & `AADM_ALM_WMASK) : 8'h00;
    assign sync_clr = (wr & sel_sync & pstrb[0]) ? pwdata[1:0] : 2'b00;

    ////////////////////////////////////////////////////////////////////////////
    // Alarm output and mute

    // Bits without a mask bit (chip reset) always reach the output
    always_comb begin
        alarm_gate = 8'hFF;
        alarm_gate[`AADM_ALM_LINK_DOWN] = ~s_q.alarm_mask[`AADM_ALM_LINK_DOWN];
        alarm_gate[`AADM_ALM_LINK_TMO] = ~s_q.alarm_mask[`AADM_ALM_LINK_TMO];
        alarm_gate[`AADM_ALM_LANE_CRC] = ~s_q.alarm_mask[`AADM_ALM_LANE_CRC];
        alarm_gate[`AADM_ALM_SYSREF] = ~s_q.alarm_mask[`AADM_ALM_SYSREF];
    end

    // Auto recovery unmutes on link up but leaves the alarm bit set
    assign mute_link = s_q.alarm[`AADM_ALM_LINK_DOWN]
        & ~(s_q.dac_mute_recovery[`AADM_REC_LINK] & link_up);

    assign mute_crc = ~s_q.mute_mask[`AADM_MMASK_CRC] & s_q.alarm[`AADM_ALM_LANE_CRC]
        & ~(s_q.dac_mute_recovery[`AADM_REC_CRC] & ~crc_now);

    assign mute_sysref = ~s_q.mute_mask[`AADM_MMASK_SYSREF] & s_q.alarm[`AADM_ALM_SYSREF];

    ////////////////////////////////////////////////////////////////////////////
    // Read mux

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_sync) begin
            rd_mux[1:0] = s_q.sync_flags;
        end else if (sel_alarm) begin
            rd_mux[7:0] = s_q.alarm;
        end else if (sel_amask) begin
            rd_mux[7:0] = s_q.alarm_mask;
        end else if (sel_mmask) begin
            rd_mux[7:0] = s_q.mute_mask;
        end else if (sel_rec) begin
            rd_mux[7:0] = s_q.dac_mute_recovery;
        end else if (sel_ctrl) begin
            rd_mux = s_q.link_ctrl;
        end else if (sel_tmo) begin
            rd_mux[23:0] = s_q.timeout;
        end else if (sel_state) begin
            rd_mux[0] = s_q.alarm_out;
            rd_mux[1] = s_q.mute_out;
            rd_mux[2] = link_up;
            rd_mux[3] = mute_link;
            rd_mux[4] = mute_crc;
            rd_mux[5] = mute_sysref;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d = s_q;
        s_d.link_up_prev = link_up;
        s_d.alarm = w1c(s_q.alarm, alarm_clr, alarm_set);
        s_d.sync_flags = (s_q.sync_flags & ~sync_clr) | sync_set;
        if (wr & sel_amask & pstrb[0]) begin
            s_d.alarm_mask = pwdata[7:0];
        end
        if (wr & sel_mmask & pstrb[0]) begin
            s_d.mute_mask = pwdata[7:0];
        end
        if (wr & sel_rec & pstrb[0]) begin
            s_d.dac_mute_recovery = pwdata[7:0];
        end
        if (wr & sel_ctrl) begin
            for (int i = 0; i < 4; i++) begin
                if (pstrb[i]) begin
                    s_d.link_ctrl[8*i +: 8] = pwdata[8*i +: 8];
                end
            end
        end
        if (wr & sel_tmo) begin
            for (int i = 0; i < 3; i++) begin
                if (pstrb[i]) begin
                    s_d.timeout[8*i +: 8] = pwdata[8*i +: 8];
                end
            end
        end
        if (rd_setup) begin
            s_d.rdata = rd_mux;
        end
        s_d.alarm_out = |(s_q.alarm & alarm_gate);
        s_d.mute_out = mute_link | mute_crc | mute_sysref;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            // Leaving reset shows the chip reset alarm already set
            s_q <= '{
                alarm: `AADM_ALM_RST,
                alarm_mask: `AADM_ALARM_OUTPUT_MASK_RST,
                mute_mask: `AADM_MUTE_MASK_RST,
                dac_mute_recovery: `AADM_DAC_MUTE_RECOVERY_RST,
                sync_flags: 2'h0,
                link_ctrl: `AADM_CTL_RST,
                timeout: `AADM_TMO_RST,
                link_up_prev: 1'b0,
                rdata: 32'h0000_0000,
                alarm_out: 1'b0,
                mute_out: 1'b0
            };
        end else begin
            s_q <= s_d;
        end
    end

    assign alarm_out = s_q.alarm_out;
    assign dac_mute = s_q.mute_out;
endmodule
`default_nettype wire

/* File: verification/aadm_top_bench.sv */
// Self-checking bench for the alarm and DAC mute supervisor
`default_nettype none
`include "aadm_defines.svh"
module aadm_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] A_SYNC = `AADM_IDX_SYNC_STATUS << 2;
    localparam logic [15:0] A_ALM = `AADM_IDX_ALARM_STATUS << 2;
    localparam logic [15:0] A_AMASK = `AADM_IDX_ALARM_MASK << 2;
    localparam logic [15:0] A_MMASK = `AADM_IDX_MUTE_MASK << 2;
    localparam logic [15:0] A_REC = `AADM_IDX_DAC_MUTE_RECOVERY << 2;
    localparam logic [15:0] A_CTRL = `AADM_IDX_LINK_CTRL << 2;
    localparam logic [15:0] A_TMO = `AADM_IDX_LINK_TIMEOUT << 2;
    logic clock = 1'h0;
    logic sys_rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] ev = 5'h00;
    logic link_up = 1'h1;
    logic [15:0] crc = 16'h0000;
    logic [3:0] strb = 4'hF;
    logic sle;
    logic alarm_out;
    logic dac_mute;
    logic [31:0] r;
    logic e;
    logic [7:0] m;
    int n_mismatch = 0;
    int cmp_count = 0;
    integer seed = 32'hFDA67D95;
    aadm_top i_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nco_sync_event(ev[0]), .sysref_event(ev[1]), .sysref_misalign_div(ev[2]),
        .sysref_misalign_link(ev[3]), .link_up(link_up), .lane_crc_fault(crc), .soft_reset_event(ev[4]),
        .alarm_out(alarm_out), .dac_mute(dac_mute), .serial_link_enable(sle));
    always #4 clock = ~clock;
    ////////////////////////////////////////////////////////////////
    // Status bit 1 has no mask; mask bits 4:1 are storage only
    function automatic logic exp_alarm(input logic [7:0] st, input logic [7:0] msk);
        return |(st & ~(msk & 8'hE1));
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // Slave answers in the first access cycle; only the watchdog ends a hang
        chk(32'(n), 32'h1);
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdm(input logic [15:0] a, input logic [31:0] msk, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk(r & msk, x);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic pulse(input int b);
        @(posedge clock);
        ev[b] <= 1'h1;
        @(posedge clock);
        ev[b] <= 1'h0;
    endtask
    task automatic drive(input logic l, input logic [15:0] c);
        @(posedge clock);
        link_up <= l;
        crc <= c;
    endtask
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        summarize;
    end
    initial begin
        tick(10);
        sys_rst <= 1'h0;
        tick(2);
        chk1(alarm_out, 1'h1);
        rdm(A_ALM, 32'hFF, 32'h02);
        rdm(A_AMASK, 32'hFF, 32'h00);
        rdm(A_MMASK, 32'hFF, 32'h21);
        rdm(A_REC, 32'hFF, 32'hA0);
        // A write whose low byte lane is off must not reach an 8-bit register
        strb <= 4'h0;
        wr(A_AMASK, 32'hFF);
        strb <= 4'hF;
        rdm(A_AMASK, 32'hFF, 32'h00);
        apb(1'h0, 16'h1200, 32'h0);
        chk1(e, 1'h1);
        chk(r, 32'h0);
        wr(A_ALM, 32'hFF);
        rdm(A_ALM, 32'hFF, 32'h00);
        tick(2);
        chk1(alarm_out, 1'h0);
        pulse(4);
        rdm(A_ALM, 32'hFF, 32'h02);
        wr(A_ALM, 32'h02);
        pulse(0);
        pulse(1);
        rdm(A_SYNC, 32'hFF, 32'h03);
        wr(A_SYNC, 32'h02);
        rdm(A_SYNC, 32'hFF, 32'h01);
        wr(A_SYNC, 32'h01);
        rdm(A_SYNC, 32'hFF, 32'h00);
        pulse(1);
        rdm(A_SYNC, 32'hFF, 32'h01);
        pulse(2);
        rdm(A_ALM, 32'hFF, 32'h01);
        chk1(alarm_out, 1'h1);
        chk1(dac_mute, 1'h0);
        wr(A_AMASK, 32'h01);
        tick(2);
        chk1(alarm_out, 1'h0);
        wr(A_AMASK, 32'h00);
        wr(A_MMASK, 32'h20);
        pulse(2);
        tick(2);
        chk1(dac_mute, 1'h1);
        wr(A_ALM, 32'h00);
        rdm(A_ALM, 32'hFF, 32'h01);
        wr(A_ALM, 32'h01);
        tick(2);
        chk1(dac_mute, 1'h0);
        wr(A_MMASK, 32'h21);
        pulse(3);
        rdm(A_ALM, 32'hFF, 32'h00);
        wr(A_TMO, 32'h5);
        rdm(A_TMO, 32'hFF_FFFF, 32'h5);
        wr(A_CTRL, 32'h1);
        pulse(3);
        rdm(A_ALM, 32'hFF, 32'h01);
        chk1(sle, 1'h1);
        wr(A_ALM, 32'h01);
        drive(1'h0, 16'h0000);
        rdm(A_ALM, 32'hC0, 32'h80);
        tick(20);
        rdm(A_ALM, 32'hC0, 32'hC0);
        chk1(dac_mute, 1'h1);
        rdm(`AADM_IDX_SUPV_STATE << 2, 32'h3F, 32'h0B);
        for (int i = 0; i < 8; i++) begin
            m = (i == 0) ? 8'hC0 : (i == 1) ? 8'h3F : 8'($random(seed));
            wr(A_AMASK, {24'h0, m});
            wr(A_MMASK, {24'h0, m});
            rdm(A_AMASK, 32'hFF, {24'h0, m});
            rdm(A_MMASK, 32'hFF, {24'h0, m});
            chk1(alarm_out, exp_alarm(8'hC0, m));
        end
        wr(A_AMASK, 32'h00);
        wr(A_MMASK, 32'h21);
        drive(1'h1, 16'h0000);
        tick(3);
        chk1(dac_mute, 1'h0);
        rdm(A_ALM, 32'h80, 32'h80);
        wr(A_ALM, 32'hC0);
        wr(A_REC, 32'h20);
        drive(1'h0, 16'h0000);
        tick(2);
        drive(1'h1, 16'h0000);
        tick(3);
        chk1(dac_mute, 1'h1);
        wr(A_ALM, 32'hC0);
        tick(2);
        chk1(dac_mute, 1'h0);
        wr(A_REC, 32'hA0);
        wr(A_CTRL, 32'h103);
        drive(1'h1, 16'h0002);
        drive(1'h1, 16'h0000);
        rdm(A_ALM, 32'h20, 32'h00);
        wr(A_MMASK, 32'h01);
        drive(1'h1, 16'h0001);
        tick(3);
        chk1(dac_mute, 1'h1);
        drive(1'h1, 16'h0000);
        tick(3);
        chk1(dac_mute, 1'h0);
        rdm(A_ALM, 32'h20, 32'h20);
        wr(A_ALM, 32'h20);
        wr(A_REC, 32'h80);
        drive(1'h1, 16'h0001);
        drive(1'h1, 16'h0000);
        tick(3);
        chk1(dac_mute, 1'h1);
        wr(A_ALM, 32'h20);
        tick(2);
        chk1(dac_mute, 1'h0);
        wr(A_MMASK, 32'h21);
        drive(1'h1, 16'h0001);
        drive(1'h1, 16'h0000);
        tick(3);
        chk1(dac_mute, 1'h0);
        wr(A_ALM, 32'h20);
        wr(A_CTRL, 32'h101);
        drive(1'h1, 16'h0001);
        drive(1'h1, 16'h0000);
        rdm(A_ALM, 32'h20, 32'h00);
        // Pin reset in mid-run must set the chip reset alarm again
        sys_rst <= 1'h1;
        tick(2);
        sys_rst <= 1'h0;
        tick(2);
        chk1(sle, 1'h0);
        chk1(alarm_out, 1'h1);
        rdm(A_ALM, 32'hFF, 32'h02);
        rdm(A_MMASK, 32'hFF, 32'h21);
        summarize;
    end
endmodule
`default_nettype wire

/* File: verification/aadm_top_chk.sv */
// Port-level assertions for the alarm and DAC mute supervisor
`default_nettype none
`include "aadm_defines.svh"
module aadm_top_chk (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sysref_misalign_div,
    input wire logic link_up,
    input wire logic alarm_out,
    input wire logic dac_mute,
    input wire logic serial_link_enable
);
    localparam logic [15:0] A_AMASK = `AADM_IDX_ALARM_MASK << 2;
    localparam logic [15:0] A_MMASK = `AADM_IDX_MUTE_MASK << 2;
    localparam logic [15:0] A_CTRL = `AADM_IDX_LINK_CTRL << 2;
    logic [7:0] amask_q;
    logic [7:0] mmask_q;
    logic wr_en;
    logic mapped;
    assign wr_en = psel && penable && pwrite && pstrb[0];
    assign mapped = paddr inside {`AADM_IDX_SYNC_STATUS << 2, `AADM_IDX_ALARM_STATUS << 2, A_AMASK, A_MMASK,
        `AADM_IDX_DAC_MUTE_RECOVERY << 2, A_CTRL, `AADM_IDX_LINK_TIMEOUT << 2, `AADM_IDX_SUPV_STATE << 2};
    // Shadow masks so mute and alarm checks know when they apply
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            amask_q <= `AADM_ALARM_OUTPUT_MASK_RST;
            mmask_q <= `AADM_MUTE_MASK_RST;
        end else begin
            if (wr_en && paddr == A_AMASK) begin
                amask_q <= pwdata[7:0];
            end
            if (wr_en && paddr == A_MMASK) begin
                mmask_q <= pwdata[7:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_link_drop;
        $fell(link_up) && serial_link_enable ##1 !link_up;
    endsequence
    AST_READY: assert property (pready == (psel && penable))
        else $error("pready does not match the access phase");
    AST_SLVERR: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    AST_UNMAPPED_RD: assert property (psel && !penable && !pwrite && !mapped |=> prdata == 32'h0)
        else $error("unmapped read returned nonzero data");
    AST_PRDATA_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("prdata changed outside a read setup");
    AST_RST_ALARM: assert property ($fell(sys_rst) |=> alarm_out)
        else $error("chip reset alarm not on alarm output after reset");
    AST_RST_NOMUTE: assert property ($fell(sys_rst) |-> !dac_mute [*2])
        else $error("mute active right after reset");
    AST_LINK_EN_WR: assert property (wr_en && paddr == A_CTRL |=> serial_link_enable == $past(pwdata[0]))
        else $error("link enable not taken from write");
    AST_LINK_MUTE: assert property (s_link_drop |=> dac_mute)
        else $error("link drop did not mute");
    AST_SYSREF_MISALIGN_ALARM: assert property (sysref_misalign_div && !amask_q[0] |-> ##2 alarm_out)
        else $error("misaligned sysref did not raise alarm output");
    AST_SYSREF_MUTE: assert property (sysref_misalign_div && !mmask_q[0] |-> ##2 dac_mute)
        else $error("misaligned sysref did not mute");
endmodule
bind aadm_top aadm_top_chk i_chk (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sysref_misalign_div(sysref_misalign_div), .link_up(link_up),
    .alarm_out(alarm_out), .dac_mute(dac_mute), .serial_link_enable(serial_link_enable));
`default_nettype wire
